// File: sram_burst_buffer.sv
`timescale 1ns/100ps

package sram_port_pkg;
   localparam int ADDR_W = 19;
   localparam int DEPTH = 524288;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int DATA_W = LANES * LANE_W;
   localparam int BURST_W = 2;
   localparam int BUF_ENTRIES = 2;
   localparam int READ_LATENCY = 1;
   localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
   localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
   localparam logic [LANES-1:0] LANES_NONE = 4'h0;
   localparam logic [LANES-1:0] LANES_ALL = 4'hF;
   localparam int ENT_W = ADDR_W + LANES + DATA_W;
endpackage : sram_port_pkg

////////////////////////////////////////////////////////////////////////////////

module sram_burst_buffer
   import sram_port_pkg::*;
#(
   parameter int W = ENT_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   // View of held entries, head first
   output logic [1:0] ent_valid,
   output logic [W-1:0] ent0,
   output logic [W-1:0] ent1
);

   logic [1:0] count_r;
   logic [W-1:0] e0_r;
   logic [W-1:0] e1_r;
   logic push;
   logic pop;

   initial begin
      if (W < 1) $error("sram_burst_buffer: width must be positive");
   end

   assign in_ready = (count_r != 2'h2);
   assign out_valid = (count_r != 2'h0);
   assign out_data = e0_r;
   assign ent_valid = {count_r == 2'h2, count_r != 2'h0};
   assign ent0 = e0_r;
   assign ent1 = e1_r;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (srst) begin
         count_r <= 2'h0;
      end else if (push && !pop) begin
         count_r <= count_r + 2'h1;
      end else if (pop && !push) begin
         count_r <= count_r - 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (push && pop) begin
         if (count_r == 2'h1) begin
            e0_r <= in_data;
         end else begin
            e0_r <= e1_r;
            e1_r <= in_data;
         end
      end else if (push) begin
         if (count_r == 2'h0) begin
            e0_r <= in_data;
         end else begin
            e1_r <= in_data;
         end
      end else if (pop) begin
         e0_r <= e1_r;
      end
   end

endmodule : sram_burst_buffer

// File: sram_sync_port.sv
`timescale 1ns/100ps

// Function
// - An edge with a strobe taken and the chip selected captures the address.
// - A taken processor strobe with the chip selected latches the address and seeds the counter.
// - The two lowest address bits feed a two-bit burst counter.
// - Byte lane selects only write their lanes together with the byte gate.
// - A byte write happens only when the byte write gate is sampled low.
// - The all-bytes write input writes every lane, ignoring the others.
// - Every synchronous input is taken on the rising clock edge.
// - Advance sampled low during a burst steps the burst counter.
// - Selection needs primary low, high select high and third select low.
// - The processor strobe is ignored while the primary select is high.
// - With both strobes low and primary select low only the processor strobe is acted on.
// - Output enable low drives the data pins, high releases them.
// - The first clock of a read after deselect keeps the pins released.
// - Without a third select pin that select counts as always active.
// - A taken controller strobe with the chip selected captures the address and seeds the counter.
// - Read data belongs to the address captured one edge earlier.
module sram_sync_port
   import sram_port_pkg::*;
#(
   parameter int DEPTH_WORDS = DEPTH,
   parameter bit HAS_THIRD_SELECT = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Address and burst control
   input wire logic [ADDR_W-1:0] addr,
   input wire logic processor_address_strobe_n,
   input wire logic controller_address_strobe_n,
   input wire logic burst_advance_n,
   // Chip selects
   input wire logic chip_select_primary_n,
   input wire logic chip_select_high,
   input wire logic chip_select_third_n,
   // Write controls
   input wire logic all_bytes_write_n,
   input wire logic byte_write_gate_n,
   input wire logic [LANES-1:0] byte_lane_select_n,
   // Data pins, lane bit 8 is extra_lane_bits
   input wire logic output_enable_n,
   input wire logic [DATA_W-1:0] dq_in,
   output logic [DATA_W-1:0] dq_out,
   output logic dq_oe,
   // Write buffer room
   output logic write_ready
);

   initial begin
      if (DEPTH_WORDS < 4 || DEPTH_WORDS > DEPTH || DEPTH_WORDS % 4 != 0)
         $error("sram_sync_port: unsupported depth");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Strobe decode

   logic third_ok;
   logic selected;
   logic proc_go;
   logic ctrl_go;
   logic start;
   logic start_sel;
   logic [LANES-1:0] lane_mask;
   logic wr_req;

   assign third_ok = HAS_THIRD_SELECT ? !chip_select_third_n : 1'b1;
   assign selected = !chip_select_primary_n && chip_select_high
      && third_ok;
   // Processor strobe needs primary select low
   assign proc_go = !processor_address_strobe_n
      && !chip_select_primary_n;
   assign ctrl_go = !controller_address_strobe_n && !proc_go;
   assign start = proc_go || ctrl_go;
   assign start_sel = start && selected;

   always_comb begin
      if (!all_bytes_write_n) begin
         lane_mask = LANES_ALL;
      end else if (!byte_write_gate_n) begin
         lane_mask = ~byte_lane_select_n;
      end else begin
         lane_mask = LANES_NONE;
      end
   end

   assign wr_req = (lane_mask != LANES_NONE);

   ////////////////////////////////////////////////////////////////////////////
   // Address and burst counter

   logic [ADDR_W-1:BURST_W] base_r;
   logic [BURST_W-1:0] cnt_r;
   logic [BURST_W-1:0] cnt_nxt;
   logic active_r;
   logic acc_valid;
   logic acc_write;
   logic [ADDR_W-1:0] acc_addr;

   // Two-bit count wraps inside its group of four
   assign cnt_nxt = burst_advance_n ? cnt_r : cnt_r + BURST_STEP;

   always_comb begin
      acc_valid = 1'b0;
      acc_write = 1'b0;
      acc_addr = {base_r, cnt_r};
      if (start_sel) begin
         acc_valid = 1'b1;
         acc_addr = addr;
         // Processor-started cycle is always a read
         acc_write = ctrl_go && wr_req;
      end else if (!start && active_r) begin
         acc_valid = 1'b1;
         acc_write = wr_req;
         acc_addr = {base_r, cnt_nxt};
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         active_r <= 1'b0;
      end else if (start) begin
         active_r <= selected;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         base_r <= '0;
         cnt_r <= BURST_RST;
      end else if (start_sel) begin
         base_r <= addr[ADDR_W-1:BURST_W];
         cnt_r <= addr[BURST_W-1:0];
      end else if (!start && active_r) begin
         cnt_r <= cnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write buffer and array

   logic buf_in_ready;
   logic buf_out_valid;
   logic drain_ok;
   logic [ENT_W-1:0] buf_out;
   logic [1:0] held;
   logic [ENT_W-1:0] held0;
   logic [ENT_W-1:0] held1;
   logic [DATA_W-1:0] mem [DEPTH_WORDS];
   logic rd_pending_r;
   logic [ADDR_W-1:0] rd_addr_r;

   // Array is single-ported, reads win
   assign drain_ok = !rd_pending_r;
   assign write_ready = buf_in_ready;

   sram_burst_buffer #(
      .W(ENT_W)
   ) u_wbuf (
      .clk(clk),
      .srst(srst),
      .in_valid(acc_valid && acc_write),
      .in_ready(buf_in_ready),
      .in_data({acc_addr, lane_mask, dq_in}),
      .out_valid(buf_out_valid),
      .out_ready(drain_ok),
      .out_data(buf_out),
      .ent_valid(held),
      .ent0(held0),
      .ent1(held1)
   );

   function automatic logic [DATA_W-1:0] merge(
      input logic [DATA_W-1:0] word,
      input logic [ENT_W-1:0] ent,
      input logic [ADDR_W-1:0] at
   );
      logic [DATA_W-1:0] res;
      res = word;
      if (ent[ENT_W-1 -: ADDR_W] == at) begin
         for (int i = 0; i < LANES; i++) begin
            if (ent[DATA_W+i]) begin
               res[i*LANE_W +: LANE_W] = ent[i*LANE_W +: LANE_W];
            end
         end
      end
      return res;
   endfunction : merge

   always_ff @(posedge clk) begin
      if (buf_out_valid && drain_ok) begin
         for (int i = 0; i < LANES; i++) begin
            if (buf_out[DATA_W+i]) begin
               mem[buf_out[ENT_W-1 -: ADDR_W]][i*LANE_W +: LANE_W] <=
                  buf_out[i*LANE_W +: LANE_W];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read pipeline and output enable

   logic [DATA_W-1:0] rd_word;
   logic [DATA_W-1:0] dout_r;
   logic out_en_r;

   // Pending writes are newer than the array, tail newest
   always_comb begin
      rd_word = mem[rd_addr_r];
      if (held[0]) rd_word = merge(rd_word, held0, rd_addr_r);
      if (held[1]) rd_word = merge(rd_word, held1, rd_addr_r);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rd_pending_r <= 1'b0;
         rd_addr_r <= '0;
      end else begin
         rd_pending_r <= acc_valid && !acc_write;
         rd_addr_r <= acc_addr;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         dout_r <= '0;
      end else if (rd_pending_r) begin
         dout_r <= rd_word;
      end
   end

   // Low in the first clock of a read, masking output enable
   always_ff @(posedge clk) begin
      if (srst) begin
         out_en_r <= 1'b0;
      end else begin
         out_en_r <= rd_pending_r;
      end
   end

   assign dq_out = dout_r;
   assign dq_oe = !output_enable_n && out_en_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   a_addr_capture: assert property (
      start_sel |=> base_r == $past(addr[ADDR_W-1:BURST_W]) && active_r)
      else $error("address not captured on a taken strobe");

   a_seed_load: assert property (
      start_sel |=> cnt_r == $past(addr[BURST_W-1:0]))
      else $error("burst counter not seeded from low address bits");

   a_burst_step: assert property (
      active_r && !start && !burst_advance_n
      |=> cnt_r == $past(cnt_r) + BURST_STEP)
      else $error("burst counter did not step");

   a_burst_hold: assert property (
      active_r && !start && burst_advance_n |=> cnt_r == $past(cnt_r))
      else $error("burst counter moved without advance");

   a_gate_needed: assert property (
      all_bytes_write_n && byte_write_gate_n |-> !acc_write)
      else $error("byte write without the byte write gate");

   a_global_write: assert property (
      !all_bytes_write_n |-> lane_mask == LANES_ALL)
      else $error("global write missed a lane");

   a_deselect_stop: assert property (
      start && !selected |=> !active_r ##1 !out_en_r)
      else $error("access while deselected");

   a_proc_ignored: assert property (
      chip_select_primary_n && controller_address_strobe_n && !active_r
      |=> !active_r)
      else $error("processor strobe taken with primary select high");

   a_strobe_priority: assert property (
      proc_go && !controller_address_strobe_n && selected && wr_req
      |-> acc_valid && !acc_write)
      else $error("controller strobe acted on beside processor strobe");

   a_oe_release: assert property (
      output_enable_n |-> !dq_oe)
      else $error("data pins driven with output enable high");

   a_first_masked: assert property (
      !active_r && !rd_pending_r && start_sel |=> !dq_oe)
      else $error("output enable not masked on first read clock");

   a_read_latency: assert property (
      acc_valid && !acc_write |=> rd_pending_r ##1 out_en_r)
      else $error("read data not presented after one edge");

   a_proc_blocked: assert property (
      active_r && chip_select_primary_n && controller_address_strobe_n
      |-> acc_valid)
      else $error("processor strobe ended a burst with primary high");

   a_third_absent: assert property (
      !HAS_THIRD_SELECT && !chip_select_primary_n && chip_select_high
      |-> selected)
      else $error("missing third select pin blocked selection");

   a_gate_low: assert property (
      all_bytes_write_n && !byte_write_gate_n && start_sel && ctrl_go
      && byte_lane_select_n != LANES_ALL |-> acc_write)
      else $error("byte write gate low with a lane selected did not write");

   a_burst_group: assert property (
      active_r && !start |-> acc_addr[ADDR_W-1:BURST_W] == base_r)
      else $error("burst address left its group of four");

   a_oe_drive: assert property (
      !output_enable_n && out_en_r |-> dq_oe)
      else $error("data pins not driven with output enable low");

   a_idle_quiet: assert property (
      !active_r && !start_sel |=> !rd_pending_r)
      else $error("read issued while deselected");

   a_write_queued: assert property (
      acc_valid && acc_write && write_ready |=> held[0])
      else $error("sampled write did not enter the buffer");

   c_full_burst: cover property (
      start_sel ##1 (!burst_advance_n && !start && active_r) [* 3]);
   c_global_write: cover property (
      acc_valid && acc_write && !all_bytes_write_n);
   c_both_strobes: cover property (start_sel && proc_go
      && !controller_address_strobe_n);
   c_buffer_full: cover property (!buf_in_ready);
   c_proc_blocked: cover property (active_r && chip_select_primary_n
      && !processor_address_strobe_n);

endmodule : sram_sync_port

// File: bus_host_model.sv
`timescale 1ns/100ps

module bus_host_model
   import sram_port_pkg::*;
(
   // Clock
   input wire logic clk,
   // Synchronous bus toward the port
   output logic [ADDR_W-1:0] addr = '0,
   output logic processor_address_strobe_n = 1'h1,
   output logic controller_address_strobe_n = 1'h1,
   output logic burst_advance_n = 1'h1,
   output logic chip_select_primary_n = 1'h1,
   output logic chip_select_high = 1'h0,
   output logic chip_select_third_n = 1'h1,
   output logic all_bytes_write_n = 1'h1,
   output logic byte_write_gate_n = 1'h1,
   output logic [LANES-1:0] byte_lane_select_n = 4'hF,
   output logic [DATA_W-1:0] dq_in = '0
);
   // One bus cycle, launched just after a rising edge
   task automatic op(input logic p, c, v, g, e,
         input logic [LANES-1:0] b, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] d, input logic [2:0] cs);
      @(posedge clk);
      processor_address_strobe_n <= p;
      controller_address_strobe_n <= c;
      burst_advance_n <= v;
      all_bytes_write_n <= g;
      byte_write_gate_n <= e;
      byte_lane_select_n <= b;
      addr <= a;
      {chip_select_primary_n, chip_select_high, chip_select_third_n} <= cs;
      // Released data lines toggle, never hold stale data
      dq_in <= (g & e) ? ~dq_in : d;
   endtask : op

   // Controller strobe with the chip unselected
   task automatic dsel();
      op(1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 4'hF, ~addr, '0, 3'h0);
   endtask : dsel
endmodule : bus_host_model

// File: tb_top.sv
`timescale 1ns/100ps

module tb_top
   import sram_port_pkg::*;
;
   localparam logic [2:0] SEL = 3'h2;
   localparam logic [DATA_W-1:0] DA = 36'h9_8765_4321;
   localparam logic [DATA_W-1:0] DB = 36'h3_C3C3_C3C3;
   localparam logic [DATA_W-1:0] LM = 36'hF_F803_FE00;
   logic clk = 1'h0;
   logic srst = 1'h1;
   logic output_enable_n = 1'h0;
   logic [ADDR_W-1:0] addr;
   logic processor_address_strobe_n, controller_address_strobe_n;
   logic burst_advance_n, chip_select_primary_n, chip_select_high;
   logic chip_select_third_n, all_bytes_write_n, byte_write_gate_n;
   logic [LANES-1:0] byte_lane_select_n;
   logic [DATA_W-1:0] dq_in, dq_out;
   logic dq_oe, write_ready;
   logic dq_oe_b;
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;

   always #4 clk = ~clk;

   bus_host_model host_u (.clk, .addr, .processor_address_strobe_n,
      .controller_address_strobe_n, .burst_advance_n,
      .chip_select_primary_n, .chip_select_high, .chip_select_third_n,
      .all_bytes_write_n, .byte_write_gate_n, .byte_lane_select_n, .dq_in);

   sram_sync_port dut_u (.clk, .srst, .addr, .processor_address_strobe_n,
      .controller_address_strobe_n, .burst_advance_n,
      .chip_select_primary_n, .chip_select_high, .chip_select_third_n,
      .all_bytes_write_n, .byte_write_gate_n, .byte_lane_select_n,
      .output_enable_n, .dq_in, .dq_out, .dq_oe, .write_ready);

   // Copy built without the third select pin
   sram_sync_port #(.HAS_THIRD_SELECT(1'b0)) dut_b_u (.clk, .srst, .addr,
      .processor_address_strobe_n, .controller_address_strobe_n,
      .burst_advance_n, .chip_select_primary_n, .chip_select_high,
      .chip_select_third_n, .all_bytes_write_n, .byte_write_gate_n,
      .byte_lane_select_n, .output_enable_n, .dq_in, .dq_out(),
      .dq_oe(dq_oe_b), .write_ready());

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk_d(input logic [DATA_W-1:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %0t: data %h expected %h", $time, got, exp);
      end
   endtask : chk_d

   task automatic chk_b(input logic got, exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %0t: flag %b expected %b", $time, got, exp);
      end
   endtask : chk_b

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         $display("Error %0t: timeout", $time);
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic g, e, input logic [LANES-1:0] b,
         input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      host_u.op(1'h1, 1'h0, 1'h1, g, e, b, a, d, SEL);
   endtask : wr

   // Single read from a deselected state
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
         input logic o);
      host_u.dsel();
      host_u.op(1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 4'hF, a, '0, SEL);
      output_enable_n <= o;
      host_u.dsel();
      #1 chk_b(dq_oe, 1'h0);
      @(posedge clk);
      #1 chk_d(dq_out, e);
      chk_b(dq_oe, ~o);
   endtask : rd

   task automatic t_global();
      wr(1'h0, 1'h1, 4'hF, 19'h00010, DA);
      rd(19'h00010, DA, 1'h1);
      rd(19'h00010, DA, 1'h0);
      $display("test global done");
   endtask : t_global

   task automatic t_lanes();
      wr(1'h0, 1'h1, 4'hF, 19'h00020, DA);
      wr(1'h1, 1'h0, 4'h5, 19'h00020, DB);
      wr(1'h1, 1'h1, 4'h0, 19'h00020, ~DB);
      host_u.dsel();
      #1 chk_b(write_ready, 1'h1);
      rd(19'h00020, (DB & LM) | (DA & ~LM), 1'h0);
      $display("test lanes done");
   endtask : t_lanes

   task automatic t_burst();
      for (int i = 0; i < 4; i++) begin
         wr(1'h0, 1'h1, 4'hF, 19'h00024 + 19'(i), 36'hA00 + 36'(i));
      end
      host_u.dsel();
      host_u.op(1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 4'hF, 19'h00026, '0, SEL);
      host_u.op(1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 4'hF, '0, '0, SEL);
      for (int i = 0; i < 4; i++) begin
         if (i < 2) begin
            host_u.op(1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 4'hF, '0, '0, SEL);
         end else begin
            host_u.dsel();
         end
         #1 chk_d(dq_out, 36'hA00 + 36'((i + 2) % 4));
      end
      $display("test burst done");
   endtask : t_burst

   task automatic t_select();
      logic [2:0] cs [3] = '{3'h6, 3'h0, 3'h3};
      for (int i = 0; i < 3; i++) begin
         host_u.dsel();
         host_u.op(1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 4'hF, 19'h00010, '0, cs[i]);
         host_u.dsel();
         @(posedge clk);
         #1 chk_b(dq_oe, 1'h0);
         chk_b(dq_oe_b, i == 2);
      end
      // Burst runs on past a processor strobe with primary select high
      host_u.dsel();
      host_u.op(1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 4'hF, 19'h00024, '0, SEL);
      host_u.op(1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 4'hF, '0, '0, 3'h6);
      host_u.dsel();
      @(posedge clk);
      #1 chk_d(dq_out, 36'hA01);
      $display("test select done");
   endtask : t_select

   task automatic t_both();
      host_u.dsel();
      host_u.op(1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 4'hF, 19'h00010, DB, SEL);
      host_u.dsel();
      @(posedge clk);
      #1 chk_d(dq_out, DA);
      rd(19'h00010, DA, 1'h0);
      $display("test both done");
   endtask : t_both

   initial begin
      repeat (6) @(posedge clk);
      srst <= 1'h0;
      #1 chk_d(dq_out, '0);
      chk_b(dq_oe, 1'h0);
      chk_b(write_ready, 1'h1);
      t_global();
      t_lanes();
      t_burst();
      t_select();
      t_both();
      report_and_stop();
   end
endmodule : tb_top
